// >>> src/dlod_pkg.sv
/*
 * Shared constants and types for the data-unit load/store operand decoder:
 * instruction field positions, operand source encodings, register map.
 * Assumes a 32-bit instruction word and a 32-bit APB register bus.
 */
package dlod_pkg;

    // ********************************
    // Instruction field positions
    // ********************************
    localparam int DLOD_INSTR_W = 32;
    localparam int DLOD_CREG_LSB = 29;
    localparam int DLOD_CREG_W = 3;
    localparam int DLOD_ZBIT = 28;
    localparam int DLOD_DST_LSB = 22;
    localparam int DLOD_DST_W = 6;
    localparam int DLOD_BASE_LSB = 17;
    localparam int DLOD_REG5_W = 5;
    localparam int DLOD_OFS_LSB = 12;
    localparam int DLOD_MODE_LSB = 9;
    localparam int DLOD_MODE_W = 3;
    localparam int DLOD_SIDE_BIT = 0;
    localparam int DLOD_NPRED = 6;

    // ********************************
    // Encoding boundaries and constants
    // ********************************
    localparam logic [4:0] DLOD_BASE_A_MAX = 5'h0D;
    localparam logic [4:0] DLOD_BASE_EXC_SP = 5'h0E;
    localparam logic [4:0] DLOD_BASE_PC = 5'h0F;
    localparam logic [5:0] DLOD_SD_ZERO = 6'h3E;
    localparam logic [5:0] DLOD_SD_CEXT = 6'h3F;
    localparam logic [2:0] DLOD_CREG_NONE = 3'h0;
    localparam logic [2:0] DLOD_CREG_RSVD = 3'h7;
    localparam logic [1:0] DLOD_MODE_RSVD = 2'h3;
    localparam logic DLOD_SIDE_FIXED = 1'b1;
    localparam int DLOD_CEXT_W = 27;
    localparam int DLOD_DATA_W = 32;

    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam int DLOD_AW = 12;
    localparam logic [11:0] DLOD_CTRL_OFS = 12'h000;
    localparam logic [11:0] DLOD_STAT_OFS = 12'h004;
    localparam logic [11:0] DLOD_CNT_OFS = 12'h008;
    localparam logic [11:0] DLOD_LAST_OFS = 12'h00C;
    localparam int DLOD_CTRL_EN = 0;
    localparam int DLOD_CTRL_SQUASH = 1;
    localparam logic [1:0] DLOD_CTRL_RST = 2'h1;
    localparam int DLOD_NSTAT = 4;
    localparam int DLOD_ST_OFS = 0;
    localparam int DLOD_ST_DST = 1;
    localparam int DLOD_ST_MODE = 2;
    localparam int DLOD_ST_COND = 3;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [3:0] {
        FILE_NONE, FILE_STREAM_ADDR, FILE_SIDE_A, FILE_SIDE_B,
        FILE_VEC_B, FILE_ADDR, FILE_L_SCALAR, FILE_L_VECTOR,
        FILE_M_SCALAR, FILE_M_VECTOR, FILE_EXC_SP, FILE_PC_COPY,
        FILE_CONST_ZERO, FILE_CONST_EXT
    } dlod_file_t;

    typedef enum logic [1:0] {
        MODE_UCST5, MODE_SCST32, MODE_REG_OFS, MODE_NONE
    } dlod_mode_t;

    typedef struct packed {
        dlod_file_t file;
        logic [3:0] idx;
        logic xpath;
        logic rsvd;
    } dlod_opnd_t;

    typedef struct packed {
        logic uncond;
        logic [2:0] pred_idx;
        logic zero_sense;
        logic rsvd;
    } dlod_cond_t;

    typedef struct packed {
        dlod_opnd_t ofs;
        dlod_opnd_t base;
        dlod_opnd_t dst;
        dlod_mode_t mode;
        logic post_inc;
        logic mode_rsvd;
        dlod_cond_t cond;
    } dlod_dec_t;

endpackage

// >>> src/dlod_field_decode.sv
/*
 * Combinational field decoder for the load and store formats.
 * Assumes the caller registers its result and supplies the unit number.
 */
`timescale 1ns/1ps
module dlod_field_decode
    import dlod_pkg::*;
(
    // Instruction
    input wire logic [dlod_pkg::DLOD_INSTR_W-1:0] instr,
    input wire logic unit2,
    input wire logic store,
    // Result
    output dlod_pkg::dlod_dec_t dec
);
    import dlod_pkg::*;

    function automatic dlod_opnd_t mk(dlod_file_t f, logic [3:0] i,
                                      logic x, logic r);
        dlod_opnd_t o;
        o.file = f;
        o.idx = i;
        o.xpath = x;
        o.rsvd = r;
        return o;
    endfunction

    logic [4:0] ofs_f;
    logic [4:0] base_f;
    logic [5:0] dst_f;
    logic [2:0] mode_f;
    logic [2:0] creg;
    logic zb;

    assign ofs_f = instr[DLOD_OFS_LSB +: DLOD_REG5_W];
    assign base_f = instr[DLOD_BASE_LSB +: DLOD_REG5_W];
    assign dst_f = instr[DLOD_DST_LSB +: DLOD_DST_W];
    assign mode_f = instr[DLOD_MODE_LSB +: DLOD_MODE_W];
    assign creg = instr[DLOD_CREG_LSB +: DLOD_CREG_W];
    assign zb = instr[DLOD_ZBIT];

    always_comb begin
        // Offset field, shared by load and store
        if (ofs_f[4])
            dec.ofs = mk(FILE_ADDR, ofs_f[3:0], 1'b0, 1'b0);
        else if (ofs_f[3])
            dec.ofs = mk(FILE_SIDE_A, {1'b1, ofs_f[2:0]}, 1'b0, 1'b0);
        else if (ofs_f[2])
            dec.ofs = mk(FILE_NONE, 4'h0, 1'b0, 1'b1);
        else
            dec.ofs = mk(FILE_STREAM_ADDR, {2'h0, ofs_f[1:0]},
                         1'b0, 1'b0);

        // Base field, shared by load and store
        if (base_f[4])
            dec.base = mk(FILE_ADDR, base_f[3:0], 1'b0, 1'b0);
        else if (base_f == DLOD_BASE_EXC_SP)
            dec.base = mk(FILE_EXC_SP, 4'h0, 1'b0, 1'b0);
        else if (base_f == DLOD_BASE_PC)
            dec.base = mk(FILE_PC_COPY, 4'h0, 1'b0, 1'b0);
        else
            dec.base = mk(FILE_SIDE_A, base_f[3:0], 1'b0,
                          base_f > DLOD_BASE_A_MAX);

        // Destination or store-data field
        if (!store) begin
            case (dst_f[5:4])
                2'h0: dec.dst = mk(FILE_SIDE_A, dst_f[3:0], 1'b0, 1'b0);
                2'h1: dec.dst = mk(FILE_VEC_B, dst_f[3:0], 1'b0, 1'b0);
                2'h2: dec.dst = mk(FILE_ADDR, dst_f[3:0], 1'b0, 1'b0);
                default: begin
                    case (dst_f[3:2])
                        2'h0: dec.dst = mk(FILE_L_SCALAR,
                                           {2'h0, dst_f[1:0]}, 1'b0, 1'b0);
                        2'h1: dec.dst = mk(FILE_L_VECTOR,
                                           {2'h0, dst_f[1:0]}, 1'b0, 1'b0);
                        2'h2: dec.dst = mk(FILE_M_SCALAR,
                                           {2'h0, dst_f[1:0]}, 1'b0, 1'b0);
                        default: dec.dst = mk(FILE_M_VECTOR,
                                              {2'h0, dst_f[1:0]}, 1'b0, 1'b0);
                    endcase
                end
            endcase
        end else if (dst_f == DLOD_SD_ZERO) begin
            dec.dst = mk(FILE_CONST_ZERO, 4'h0, 1'b0, 1'b0);
        end else if (dst_f == DLOD_SD_CEXT) begin
            dec.dst = mk(FILE_CONST_EXT, 4'h0, 1'b0, 1'b0);
        end else begin
            case (dst_f[5:4])
                2'h0: dec.dst = mk(FILE_SIDE_A, dst_f[3:0], unit2, 1'b0);
                2'h1: dec.dst = unit2 ?
                          mk(FILE_VEC_B, dst_f[3:0], 1'b0, 1'b0) :
                          mk(FILE_SIDE_B, dst_f[3:0], 1'b1, 1'b0);
                2'h2: dec.dst = unit2 ? mk(FILE_NONE, 4'h0, 1'b0, 1'b1) :
                          mk(FILE_ADDR, dst_f[3:0], 1'b0, 1'b0);
                default: dec.dst = mk(FILE_NONE, 4'h0, 1'b0, 1'b1);
            endcase
        end

        // Addressing mode, shared by load and store
        dec.post_inc = mode_f[2];
        dec.mode_rsvd = (mode_f[1:0] == DLOD_MODE_RSVD);
        case (mode_f[1:0])
            2'h0: dec.mode = MODE_UCST5;
            2'h1: dec.mode = MODE_SCST32;
            2'h2: dec.mode = MODE_REG_OFS;
            default: dec.mode = MODE_NONE;
        endcase

        // Condition field
        dec.cond.zero_sense = zb;
        dec.cond.uncond = (creg == DLOD_CREG_NONE) && !zb;
        dec.cond.rsvd = (creg == DLOD_CREG_RSVD) ||
                        (creg == DLOD_CREG_NONE && zb);
        dec.cond.pred_idx = (creg == DLOD_CREG_NONE ||
                             creg == DLOD_CREG_RSVD) ? 3'h0 :
                            creg - 3'h1;
    end

endmodule

// >>> src/dlod_decoder.sv
/*
 * Data-unit scalar load/store operand and predicate decoder, one decode
 * stage register, with an APB slave for control and status.
 * Assumes the fetch stage and register files run on clk; pred_zero comes
 * from the side-A register file in the same cycle as the instruction.
 */
// Behaviour
// - Offset field: 0-3 stream address, 4-7 reserved, 8-15 side-A, 16-31 address.
// - Base field: side-A 0-13, exception stack pointer, PC copy, then address regs.
// - Load destination decodes identically on both units across seven register groups.
// - Store reuses load decoding for offset, base and addressing-mode fields.
// - Store-data ranges differ per unit, with crosspath flags and reserved range.
// - Store-data high codes reserved; zero constant; sign-extended 27-bit constant.
// - Condition select bits 31-29, zero-test bit 28; 0000 unconditional, 0001 reserved.
// - Select 1 to 6 tests side-A 0 to 5; select 7 reserved.
// - Mode field: ucst5, scst32, register offset; top bit post-increments; 3 reserved.
// - Side-select bit of every data-unit instruction decodes as fixed one.
`timescale 1ns/1ps
module dlod_decoder
    import dlod_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic [dlod_pkg::DLOD_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Instruction from fetch
    input wire logic in_valid,
    input wire logic [dlod_pkg::DLOD_INSTR_W-1:0] in_instr,
    input wire logic in_unit2,
    input wire logic in_store,
    input wire logic [dlod_pkg::DLOD_CEXT_W-1:0] cst_ext,
    // Zero flags of the tested side-A registers
    input wire logic [dlod_pkg::DLOD_NPRED-1:0] pred_zero,
    // Decoded result
    output logic out_valid,
    output dlod_pkg::dlod_dec_t out_dec,
    output logic out_side,
    output logic [dlod_pkg::DLOD_DATA_W-1:0] out_const,
    output logic out_exec,
    output logic out_illegal
);
    import dlod_pkg::*;

    // ********************************
    // Decode
    // ********************************
    dlod_dec_t dec;
    logic [1:0] ctrl;
    logic [DLOD_NSTAT-1:0] stat;
    logic [31:0] dcount;
    logic [31:0] last_instr;
    logic take;
    logic illegal;
    logic pred_hit;
    logic exec;
    logic [DLOD_NSTAT-1:0] stat_set;
    logic [DLOD_DATA_W-1:0] const_val;

    dlod_field_decode u_field (
        .instr(in_instr),
        .unit2(in_unit2),
        .store(in_store),
        .dec(dec)
    );

    // A disabled stage drops the word; nothing is queued for later
    assign take = in_valid && ctrl[DLOD_CTRL_EN];

    assign stat_set[DLOD_ST_OFS] = take && dec.ofs.rsvd;
    // Base shares status bit one with the destination field
    assign stat_set[DLOD_ST_DST] = take && (dec.dst.rsvd || dec.base.rsvd);
    assign stat_set[DLOD_ST_MODE] = take && dec.mode_rsvd;
    assign stat_set[DLOD_ST_COND] = take && dec.cond.rsvd;
    assign illegal = dec.ofs.rsvd || dec.base.rsvd || dec.dst.rsvd ||
                     dec.mode_rsvd || dec.cond.rsvd;

    // Index is at most five whenever the select is a real register
    assign pred_hit = pred_zero[dec.cond.pred_idx];

    always_comb begin
        if (dec.cond.uncond)
            exec = 1'b1;
        else if (dec.cond.rsvd)
            exec = 1'b0;
        else if (dec.cond.zero_sense)
            exec = pred_hit;
        else
            exec = !pred_hit;
        // Squashing is optional: some flows trap reserved codes later
        if (illegal && ctrl[DLOD_CTRL_SQUASH])
            exec = 1'b0;
    end

    // Only the extension code carries a value; all else reads as zero
    always_comb begin
        case (dec.dst.file)
            FILE_CONST_EXT: const_val = {{(DLOD_DATA_W - DLOD_CEXT_W)
                                          {cst_ext[DLOD_CEXT_W-1]}},
                                         cst_ext};
            default: const_val = '0;
        endcase
    end

    // ********************************
    // Decode stage register
    // ********************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_dec <= '0;
            out_side <= DLOD_SIDE_FIXED;
            out_const <= '0;
            out_exec <= 1'b0;
            out_illegal <= 1'b0;
        end else if (clk_en) begin
            // Other outputs hold so a stalled consumer still sees them
            out_valid <= take;
            if (take) begin
                out_dec <= dec;
                // Both data units sit on side A, whatever the bit holds
                out_side <= DLOD_SIDE_FIXED;
                out_const <= const_val;
                out_exec <= exec;
                out_illegal <= illegal;
            end
        end
    end

    // ********************************
    // APB slave
    // ********************************
    logic acc;
    logic wr_done;
    logic mapped;
    logic [31:0] rd_val;

    assign acc = psel && penable && !pready;
    assign wr_done = psel && penable && pready && pwrite;

    // ********************************
    // Register write strobes
    // ********************************
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cnt;

    // A write lands on the pready edge only, so each access writes once
    assign wr_ctrl = wr_done && (paddr == DLOD_CTRL_OFS);
    assign wr_stat = wr_done && (paddr == DLOD_STAT_OFS);
    assign wr_cnt = wr_done && (paddr == DLOD_CNT_OFS);

    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        case (paddr)
            DLOD_CTRL_OFS: rd_val = {30'h0, ctrl};
            DLOD_STAT_OFS: rd_val = {{(32 - DLOD_NSTAT){1'b0}}, stat};
            DLOD_CNT_OFS: rd_val = dcount;
            DLOD_LAST_OFS: rd_val = last_instr;
            default: mapped = 1'b0;
        endcase
    end

    // One wait state: answer comes on the second access cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= acc;
            prdata <= (acc && !pwrite) ? rd_val : '0;
            // Unmapped reads give zero data; writes there are dropped
            pslverr <= acc && !mapped;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ctrl <= DLOD_CTRL_RST;
        else if (clk_en && wr_ctrl)
            ctrl <= pwdata[1:0];
    end

    // Sticky reserved-encoding flags, write one to clear; a new hit wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            stat <= '0;
        else if (clk_en) begin
            if (wr_stat)
                stat <= (stat & ~pwdata[DLOD_NSTAT-1:0]) | stat_set;
            else
                stat <= stat | stat_set;
        end
    end

    // Decoded-instruction count, any write clears it, or sets it to one if a decode lands in that cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            dcount <= '0;
        else if (clk_en) begin
            if (wr_cnt)
                dcount <= {31'h0, take};
            else if (take)
                dcount <= dcount + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            last_instr <= '0;
        else if (clk_en && take)
            last_instr <= in_instr;
    end

endmodule

// >>> sim/dlod_decoder_assertions.sv
/* Property checker for dlod_decoder, bound to its ports.
   Assumes one clk domain and the async active-low reset. */
`timescale 1ns/1ps
module dlod_checker
    import dlod_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // APB answer
    input wire logic pready,
    // Fetch side
    input wire logic in_valid,
    input wire logic [31:0] in_instr,
    input wire logic in_store,
    input wire logic [26:0] cst_ext,
    // Decoded result
    input wire logic out_valid,
    input wire dlod_pkg::dlod_dec_t out_dec,
    input wire logic out_side,
    input wire logic [31:0] out_const,
    input wire logic out_exec,
    input wire logic out_illegal
);
    logic tk;
    assign tk = in_valid && clk_en;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ********************************
    // Properties
    // ********************************
    side_fixed_a: assert property (out_side)
        else $error("side bit not one");
    ofs_rsvd_a: assert property (tk && in_instr[16:14] == 3'h1
        ##1 out_valid |-> out_dec.ofs.rsvd && out_illegal)
        else $error("offset reserved missed");
    ofs_addr_a: assert property (tk && in_instr[16] ##1 out_valid
        |-> out_dec.ofs.file == FILE_ADDR
        && out_dec.ofs.idx == $past(in_instr[15:12]))
        else $error("offset address map wrong");
    base_sp_a: assert property (tk && in_instr[21:17] == 5'h0E
        ##1 out_valid |-> out_dec.base.file == FILE_EXC_SP)
        else $error("base stack pointer code wrong");
    cext_a: assert property (tk && in_store && in_instr[27:22] == 6'h3F
        ##1 out_valid |-> out_const
        == {{5{$past(cst_ext[26])}}, $past(cst_ext)})
        else $error("constant extension wrong");
    cond_rsvd_a: assert property (tk && in_instr[31:29] == 3'h7
        ##1 out_valid |-> out_dec.cond.rsvd && !out_exec)
        else $error("reserved condition executed");
    mode_bits_a: assert property (tk ##1 out_valid
        |-> out_dec.post_inc == $past(in_instr[11])
        && out_dec.mode_rsvd == ($past(in_instr[10:9]) == 2'h3))
        else $error("mode field decode wrong");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    cover property (tk && in_store ##1 out_valid);
    cover property (out_valid && out_illegal);
    cover property (out_valid && out_exec);
endmodule

bind dlod_decoder dlod_checker chk_i (
    .clk, .arst_n, .clk_en, .pready, .in_valid, .in_instr, .in_store,
    .cst_ext, .out_valid, .out_dec, .out_side, .out_const, .out_exec,
    .out_illegal
);

// >>> sim/dunit_ldst_operand_decode_tb_top.sv
/* Self-checking bench for dlod_decoder.
   Drives fetch and APB ports directly; clk_en held high except for one frozen decode. */
`timescale 1ns/1ps
module dunit_ldst_operand_decode_tb_top;
    import dlod_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic in_valid = 1'b0;
    logic in_unit2 = 1'b0;
    logic in_store = 1'b0;
    logic [31:0] in_instr = 32'h0;
    logic [26:0] cst_ext = 27'h4000123;
    logic [5:0] pred_zero = 6'h00;
    logic pready, pslverr, out_valid, out_side, out_exec, out_illegal;
    logic [31:0] prdata, out_const, rd;
    dlod_dec_t out_dec;
    dlod_opnd_t e;
    logic [9:0] m;
    logic [4:0] k;
    logic [5:0] d, zz, cm;
    logic [3:0] q;
    logic err, x, r;
    int n_fail = 0;
    int cmp_count = 0;
    int n_dec = 0;
    int cyc = 0;

    dlod_decoder uut (
        .clk, .arst_n, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pready, .prdata, .pslverr, .in_valid, .in_instr, .in_unit2,
        .in_store, .cst_ext, .pred_zero, .out_valid, .out_dec, .out_side,
        .out_const, .out_exec, .out_illegal
    );

    always #5 clk = ~clk;

    // Hang guard, about three and a half times the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            end_sim();
        end
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string w, input logic [39:0] ex, ob);
        cmp_count++;
        if (ob !== ex) begin
            $display("Error %s exp %h got %h", w, ex, ob);
            n_fail++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string w, input logic [11:0] a,
        input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(w, ex, rd);
    endtask

    // Offer one word; outputs are read in the answer cycle
    task automatic dec(input logic [31:0] ins, input logic u2, st, ev);
        @(posedge clk);
        in_valid <= 1'b1;
        in_instr <= ins;
        in_unit2 <= u2;
        in_store <= st;
        @(posedge clk);
        in_valid <= 1'b0;
        @(posedge clk);
        n_dec += ev;
        chk("valid", ev, out_valid);
    endtask

    function automatic dlod_opnd_t mk(input dlod_file_t f,
        input logic [3:0] i, input logic xp, input logic rs);
        mk = '{f, i, xp, rs};
    endfunction

    // Also sets the compare mask m
    function automatic dlod_opnd_t exp_dst(input logic u, s,
        input logic [5:0] c);
        dlod_file_t f;
        logic rv;
        f = c[5] ? FILE_ADDR : c[4] ? (s && !u ? FILE_SIDE_B : FILE_VEC_B)
            : FILE_SIDE_A;
        // Store codes 10xxxx on unit two and 11xxxx on both are reserved
        rv = s && c[5] && (u || c[4]);
        m = rv ? 10'h001 : 10'h3FF;
        exp_dst = mk(f, c[3:0], s && (u ^ c[4]), rv);
        if (c[5:4] == 2'h3 && !s)
            exp_dst = mk(c[3] ? (c[2] ? FILE_M_VECTOR : FILE_M_SCALAR)
                : (c[2] ? FILE_L_VECTOR : FILE_L_SCALAR),
                {2'h0, c[1:0]}, 1'b0, 1'b0);
        else if (c[5:1] == 5'h1F) begin
            exp_dst = mk(c[0] ? FILE_CONST_EXT : FILE_CONST_ZERO,
                4'h0, 1'b0, 1'b0);
            m = 10'h3C3;
        end
    endfunction

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rdchk("ctrl", DLOD_CTRL_OFS, 32'h1);
        chk("slverr", 1'b0, err);
        rdchk("stat", DLOD_STAT_OFS, 32'h0);
        rdchk("cnt", DLOD_CNT_OFS, 32'h0);
        rdchk("unmapped", 12'h010, 32'h0);
        chk("slverr", 1'b1, err);
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 32; c++) begin
                k = 5'(c);
                dec({10'h000, k, k, 12'h000}, 1'b0, s[0], 1'b1);
                e = mk(k[4] ? FILE_ADDR : k[3] ? FILE_SIDE_A : k[2]
                    ? FILE_NONE : FILE_STREAM_ADDR, k[3:0], 1'b0,
                    k[4:2] == 3'h1);
                m = k[4:2] == 3'h1 ? 10'h3C3 : 10'h3FF;
                chk("offset", e & m, out_dec.ofs & m);
                chk("illegal", k[4:2] == 3'h1, out_illegal);
                e = mk(k[4] ? FILE_ADDR : k == 5'h0E ? FILE_EXC_SP
                    : k == 5'h0F ? FILE_PC_COPY : FILE_SIDE_A, k[3:0],
                    1'b0, 1'b0);
                m = k[4:1] == 4'h7 ? 10'h3C3 : 10'h3FF;
                chk("base", e & m, out_dec.base & m);
            end
        end
        for (int u = 0; u < 4; u++) begin
            for (int c = 0; c < 64; c++) begin
                d = 6'(c);
                dec({4'h0, d, 10'h008, 12'h000}, u[0], u[1], 1'b1);
                e = exp_dst(u[0], u[1], d);
                chk("dest", e & m, out_dec.dst & m);
                chk("illegal", e.rsvd, out_illegal);
                chk("const", (u[1] && d == 6'h3F) ? 32'hFC000123
                    : 32'h0, out_const);
            end
        end
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 16; c++) begin
                q = 4'(c);
                zz = p ? 6'h2A : 6'h15;
                pred_zero <= zz;
                dec({q, 28'h0008000}, 1'b0, 1'b0, 1'b1);
                r = q == 4'h1 || q[3:1] == 3'h7;
                x = q[3:1] == 3'h0 ? !q[0] : q[3:1] == 3'h7 ? 1'b0
                    : q[0] ~^ zz[q[3:1] - 3'h1];
                cm = (q[3:1] == 3'h0 || r) ? 6'h21 : 6'h3F;
                chk("exec", x, out_exec);
                chk("illegal", r, out_illegal);
                chk("cond", {q == 4'h0, q[3:1] - 3'h1, q[0], r} & cm,
                    out_dec.cond & cm);
            end
        end
        for (int c = 0; c < 8; c++) begin
            q = 4'(c);
            dec({20'h00008, q[2:0], 8'h00, q[0]}, 1'b0, 1'b0, 1'b1);
            r = q[1:0] == 2'h3;
            chk("mode", {r ? 2'h0 : q[1:0], q[2], r},
                {r ? 2'h0 : 2'(out_dec.mode), out_dec.post_inc,
                out_dec.mode_rsvd});
            chk("illegal", r, out_illegal);
            chk("side", 1'b1, out_side);
        end
        rdchk("last", DLOD_LAST_OFS, in_instr);
        apb(1'b1, DLOD_LAST_OFS, 32'hFFFFFFFF);
        rdchk("last ro", DLOD_LAST_OFS, in_instr);
        rdchk("stat", DLOD_STAT_OFS, 32'hF);
        apb(1'b1, DLOD_STAT_OFS, 32'h5);
        rdchk("stat w1c", DLOD_STAT_OFS, 32'hA);
        rdchk("cnt", DLOD_CNT_OFS, 32'(n_dec));
        apb(1'b1, DLOD_CNT_OFS, 32'h0);
        apb(1'b1, DLOD_CTRL_OFS, 32'h3);
        pred_zero <= 6'h00;
        // Would execute, but the reserved mode is squashed
        dec(32'h20008600, 1'b0, 1'b0, 1'b1);
        chk("squash", 1'b0, out_exec);
        clk_en <= 1'b0;
        // Frozen stage: no valid, no count, the last decode still shown
        dec(32'h00008000, 1'b0, 1'b0, 1'b0);
        chk("frozen", 1'b1, out_illegal);
        clk_en <= 1'b1;
        apb(1'b1, DLOD_CTRL_OFS, 32'h0);
        dec(32'h00008000, 1'b0, 1'b0, 1'b0);
        rdchk("cnt", DLOD_CNT_OFS, 32'h1);
        end_sim();
    end
endmodule
